// File: rtl/sfp_pkg.sv
package sfp_pkg;

  // clocking and pin timing
  localparam int MCLK_MHZ  = 100;
  localparam int T_RP_NS   = 200;
  localparam int T_CS_NS   = 50;
  // least time: round up
  localparam int RP_CYCLES = (T_RP_NS * MCLK_MHZ + 999) / 1000 < 1 ? 1
                           : (T_RP_NS * MCLK_MHZ + 999) / 1000;
  // longest drive time: round down
  localparam int CS_CYCLES = (T_CS_NS * MCLK_MHZ) / 1000 < 1 ? 1
                           : (T_CS_NS * MCLK_MHZ) / 1000;
  localparam int RP_CNT_W  = $clog2(RP_CYCLES + 1);
  localparam int CS_CNT_W  = $clog2(CS_CYCLES + 1);

  // field positions
  localparam int WIP_BIT    = 1;
  localparam int SWD_BIT    = 7;
  localparam int QUAD_BIT   = 1;
  localparam int RST_EN_BIT = 5;

  // transfer geometry and reset values
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] ADDR_BYTES    = 3'h3;
  localparam logic [7:0] IDLE_TX_BYTE  = 8'hFF;
  localparam logic [4:0] MCLK_SYNC_INIT = 5'h10;

  typedef enum logic [1:0] {SFP_X1, SFP_X2, SFP_X4} sfp_width_t;

  typedef struct packed {
    logic       quadEn;
    logic       fourLine;
    logic       ddr;
    sfp_width_t width;
  } sfp_lane_cfg_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } sfp_rx_word_t;

endpackage : sfp_pkg

// File: rtl/sfp_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sfp_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // output follows once the second and third stage agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end else begin
      s1_q  <= asyncIn;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;

endmodule : sfp_sync

`default_nettype wire

// File: rtl/sfp_pin_interface.sv
// What this block does
// - capture instruction, address and input data on rising serial clock edges
// - SDR output changes after falling edges; DDR output after every edge
// - chip select high: inputs ignored, outputs high impedance except the line three hold
// - deselected means standby unless write-in-progress shows an operation running
// - chip select low enables the device and selects active power
// - after power-up, no command starts before a chip select falling edge
// - single-bit commands receive everything on data line zero only
// - single-bit commands shift read data out on line one at falling edges
// - dual and quad: lines zero and one turn bidirectional, same edge rules
// - write protect low plus disable bit silently drops status/config writes
// - quad enable disables write protect; line two becomes data
// - quad mode: line three is bidirectional data with same edge rules
// - reset enable: line three is reset only while deselected, in quad mode or not
// - reset only when chip select high and line three low for pulse time
// - after a read transfer device drives line three high for CS_CYCLES mclk cycles once deselected
// - reset enable clear: line three reset function ignored entirely
// - lowest line carries least significant bit; groups go MSB first
// - four-line command mode moves every phase as nibbles on lines 0-3
`timescale 1ns/1ns
`default_nettype none

module sfp_pin_interface #(
  parameter logic [7:0]  WRITE_REGS_OPCODE  = 8'hA1,
  parameter logic [7:0]  WRITE_ANY_OPCODE   = 8'hA2,
  parameter logic [23:0] STATUS_ONE_NV_ADDR = 24'h000000,
  parameter logic [23:0] STATUS_ONE_V_ADDR  = 24'h000001,
  parameter logic [23:0] CONFIG_ONE_NV_ADDR = 24'h000002,
  parameter logic [23:0] CONFIG_ONE_V_ADDR  = 24'h000003
) (
  // system
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // link pins
  input  wire logic              sck,
  input  wire logic              csN,
  input  wire logic [3:0]        lineIn,
  output logic      [3:0]        lineOut,
  output logic      [3:0]        lineOe,
  output logic                   line3HoldOe,
  // device registers seen by the pins
  input  wire logic [7:0]        statusOneVolatile,
  input  wire logic [7:0]        statusOneNonvolatile,
  input  wire logic [7:0]        configOneVolatile,
  input  wire logic [7:0]        configTwoVolatile,
  // transfer shape
  input  wire logic              fourLineCommandMode,
  input  wire logic              ddrMode,
  input  wire sfp_pkg::sfp_width_t laneWidth,
  // received bytes
  output logic                   rxValid,
  output sfp_pkg::sfp_rx_word_t  rxWord,
  // bytes to send
  input  wire logic              txValid,
  input  wire logic [7:0]        txData,
  output logic                   txReady,
  // events and state
  output logic                   regWriteIgnored,
  output logic                   hwReset,
  output logic                   standbyPower,
  output logic                   activePower
);
  import sfp_pkg::*;

  function automatic logic [3:0] laneBits(input sfp_width_t w);
    case (w)
      SFP_X2:  laneBits = 4'h2;
      SFP_X4:  laneBits = 4'h4;
      default: laneBits = 4'h1;
    endcase
  endfunction : laneBits

  // top bits of the byte placed on the lines, line zero least significant
  function automatic logic [3:0] laneGroup(input logic [7:0] b, input sfp_width_t w);
    case (w)
      SFP_X2:  laneGroup = {2'h0, b[7:6]};
      SFP_X4:  laneGroup = b[7:4];
      default: laneGroup = {2'h0, b[7], 1'h0};
    endcase
  endfunction : laneGroup

  function automatic logic [3:0] laneMask(input sfp_width_t w);
    case (w)
      SFP_X2:  laneMask = 4'h3;
      SFP_X4:  laneMask = 4'hF;
      default: laneMask = 4'h2;
    endcase
  endfunction : laneMask

  // ---------------- link side, serial clock domain ----------------
  sfp_lane_cfg_t cfgM, cfgS;
  logic          txReqTog_q, txReqS;
  logic          frameRst_n;
  logic          armed_q;

  always_comb begin
    cfgM.quadEn   = configOneVolatile[QUAD_BIT];
    cfgM.fourLine = fourLineCommandMode;
    cfgM.ddr      = ddrMode;
    cfgM.width    = laneWidth;
  end

  // config must stay still across a few serial clock edges before use
  sfp_sync #(.WIDTH($bits(sfp_lane_cfg_t)), .INIT('0)) u_cfgSync (
    .clk     (sck),
    .rst_n   (rst_n),
    .asyncIn (cfgM),
    .syncOut (cfgS)
  );

  sfp_sync #(.WIDTH(1), .INIT(1'b0)) u_txReqSync (
    .clk     (sck),
    .rst_n   (rst_n),
    .asyncIn (txReqTog_q),
    .syncOut (txReqS)
  );

  assign frameRst_n = rst_n & ~csN;

  // set while deselected, so the first command needs a falling select
  always_ff @(posedge sck or negedge rst_n or posedge csN) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (csN) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= armed_q;
    end
  end

  sfp_width_t instrW, dataW;
  always_comb begin
    dataW = cfgS.width;
    if (cfgS.width == SFP_X4 && !cfgS.quadEn) begin
      dataW = SFP_X1;
    end
    if (cfgS.fourLine) begin
      dataW = SFP_X4;
    end
    instrW = cfgS.fourLine ? SFP_X4 : SFP_X1;
  end

  // input shifting, cleared by deselect
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] rxSh_q, rxSh_d;
  logic       instrDone_q, instrDone_d;
  logic [2:0] byteCnt_q, byteCnt_d;
  logic       outMode_q, outMode_d;
  logic       byteDone, frameStart, takePend;
  sfp_width_t inW;
  logic [3:0] add;

  // persistent frame record, read by the system side per byte and at deselect
  sfp_rx_word_t rxHold_q, rxHold_d;
  logic         rxTog_q, rxTog_d;
  logic [7:0]   instr_q, instr_d;
  logic [23:0]  addr_q, addr_d;
  logic         wpLow_q, wpLow_d;
  logic         sentData_q, sentData_d;
  logic         takenTog_q;

  assign takePend = txReqS != takenTog_q;

  always_comb begin
    inW         = instrDone_q ? dataW : instrW;
    add         = laneBits(inW);
    frameStart  = !instrDone_q && bitCnt_q == 4'h0;
    bitCnt_d    = bitCnt_q;
    rxSh_d      = rxSh_q;
    instrDone_d = instrDone_q;
    byteCnt_d   = byteCnt_q;
    outMode_d   = outMode_q;
    byteDone    = 1'b0;
    rxHold_d    = rxHold_q;
    rxTog_d     = rxTog_q;
    instr_d     = instr_q;
    addr_d      = addr_q;
    wpLow_d     = wpLow_q;
    sentData_d  = frameStart ? 1'b0 : (sentData_q | outMode_q);
    if (armed_q && !outMode_q) begin
      case (inW)
        SFP_X2:  rxSh_d = {rxSh_q[5:0], lineIn[1:0]};
        SFP_X4:  rxSh_d = {rxSh_q[3:0], lineIn[3:0]};
        default: rxSh_d = {rxSh_q[6:0], lineIn[0]};
      endcase
      if (!cfgS.quadEn) begin
        wpLow_d = (frameStart ? 1'b0 : wpLow_q) | !lineIn[2];
      end else if (frameStart) begin
        wpLow_d = 1'b0;
      end
      byteDone = (bitCnt_q + add) == BITS_PER_BYTE;
      bitCnt_d = byteDone ? 4'h0 : bitCnt_q + add;
      if (byteDone) begin
        instrDone_d   = 1'b1;
        rxHold_d.data = rxSh_d;
        rxHold_d.first = !instrDone_q;
        rxTog_d       = !rxTog_q;
        if (!instrDone_q) begin
          instr_d = rxSh_d;
        end else if (byteCnt_q < ADDR_BYTES) begin
          addr_d    = {addr_q[15:0], rxSh_d};
          byteCnt_d = byteCnt_q + 3'h1;
        end
        outMode_d = instrDone_q && takePend;
      end
    end
  end

  always_ff @(posedge sck or negedge frameRst_n) begin
    if (!frameRst_n) begin
      bitCnt_q    <= 4'h0;
      rxSh_q      <= 8'h00;
      instrDone_q <= 1'b0;
      byteCnt_q   <= 3'h0;
      outMode_q   <= 1'b0;
    end else begin
      bitCnt_q    <= bitCnt_d;
      rxSh_q      <= rxSh_d;
      instrDone_q <= instrDone_d;
      byteCnt_q   <= byteCnt_d;
      outMode_q   <= outMode_d;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rxHold_q   <= '0;
      rxTog_q    <= 1'b0;
      instr_q    <= 8'h00;
      addr_q     <= 24'h000000;
      wpLow_q    <= 1'b0;
      sentData_q <= 1'b0;
    end else begin
      rxHold_q   <= rxHold_d;
      rxTog_q    <= rxTog_d;
      instr_q    <= instr_d;
      addr_q     <= addr_d;
      wpLow_q    <= wpLow_d;
      sentData_q <= sentData_d;
    end
  end

  // output shifting on the falling edge
  logic [7:0] txHold_q, txHold_d;
  logic [7:0] txSh_q, txSh_d;
  logic [3:0] txLeft_q, txLeft_d;
  logic [3:0] outNeg_q, outNeg_d, posNext_q, posNext_d, outPos_q, oe_q, oe_d;
  logic       takenTog_d;

  always_comb begin
    txSh_d     = txSh_q;
    txLeft_d   = txLeft_q;
    outNeg_d   = outNeg_q;
    posNext_d  = posNext_q;
    takenTog_d = takenTog_q;
    oe_d       = outMode_q ? laneMask(dataW) : 4'h0;
    if (outMode_q) begin
      if (txLeft_q == 4'h0) begin
        txLeft_d = BITS_PER_BYTE;
        if (takePend) begin
          txSh_d     = txHold_q;
          takenTog_d = !takenTog_q;
        end else begin
          txSh_d = IDLE_TX_BYTE;
        end
      end
      outNeg_d = laneGroup(txSh_d, dataW);
      txSh_d   = txSh_d << laneBits(dataW);
      txLeft_d = txLeft_d - laneBits(dataW);
      if (cfgS.ddr) begin
        posNext_d = laneGroup(txSh_d, dataW);
        txSh_d    = txSh_d << laneBits(dataW);
        txLeft_d  = txLeft_d - laneBits(dataW);
      end
    end
  end

  always_ff @(negedge sck or negedge frameRst_n) begin
    if (!frameRst_n) begin
      txSh_q    <= 8'h00;
      txLeft_q  <= 4'h0;
      outNeg_q  <= 4'h0;
      posNext_q <= 4'h0;
      oe_q      <= 4'h0;
    end else begin
      txSh_q    <= txSh_d;
      txLeft_q  <= txLeft_d;
      outNeg_q  <= outNeg_d;
      posNext_q <= posNext_d;
      oe_q      <= oe_d;
    end
  end

  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      takenTog_q <= 1'b0;
    end else begin
      takenTog_q <= takenTog_d;
    end
  end

  // second half of each cycle in double data rate
  always_ff @(posedge sck or negedge frameRst_n) begin
    if (!frameRst_n) begin
      outPos_q <= 4'h0;
    end else begin
      outPos_q <= posNext_q;
    end
  end

  // ddr needs both edge flops on the pad; sdr uses the falling-edge flop
  assign lineOut = (cfgS.ddr && sck) ? outPos_q : outNeg_q;
  assign lineOe  = oe_q;

  // ---------------- system side, mclk domain ----------------
  logic csS, line3S, rxTogS, takenS, sentS;

  sfp_sync #(.WIDTH(5), .INIT(MCLK_SYNC_INIT)) u_mclkSync (
    .clk     (mclk),
    .rst_n   (rst_n),
    .asyncIn ({csN, lineIn[3], rxTog_q, takenTog_q, sentData_q}),
    .syncOut ({csS, line3S, rxTogS, takenS, sentS})
  );

  // received bytes
  logic         rxSeen_q, rxSeen_d, rxValid_q, rxValid_d;
  sfp_rx_word_t rxWord_q, rxWord_d;

  always_comb begin
    rxSeen_d  = rxTogS;
    rxValid_d = rxTogS != rxSeen_q;
    rxWord_d  = rxValid_d ? rxHold_q : rxWord_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxSeen_q  <= 1'b0;
      rxValid_q <= 1'b0;
      rxWord_q  <= '0;
    end else begin
      rxSeen_q  <= rxSeen_d;
      rxValid_q <= rxValid_d;
      rxWord_q  <= rxWord_d;
    end
  end

  // bytes to send, one outstanding at a time
  logic txReqTog_d, txReady_q, txReady_d, txAccept;

  always_comb begin
    txAccept   = txValid && txReady_q;
    txReqTog_d = txAccept ? !txReqTog_q : txReqTog_q;
    txHold_d   = txAccept ? txData : txHold_q;
    txReady_d  = !txAccept && (takenS == txReqTog_q);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txReqTog_q <= 1'b0;
      txHold_q   <= 8'h00;
      txReady_q  <= 1'b0;
    end else begin
      txReqTog_q <= txReqTog_d;
      txHold_q   <= txHold_d;
      txReady_q  <= txReady_d;
    end
  end

  // end of frame: protected writes and line three hold
  logic                csPrev_q, csPrev_d, csRise, cmdHit, wrLock;
  logic                ignored_q, ignored_d, hold_q, hold_d;
  logic [CS_CNT_W-1:0] holdCnt_q, holdCnt_d;

  always_comb begin
    csPrev_d  = csS;
    csRise    = csS && !csPrev_q;
    wrLock    = !configOneVolatile[QUAD_BIT] && statusOneNonvolatile[SWD_BIT]
                && wpLow_q;
    cmdHit    = instr_q == WRITE_REGS_OPCODE
                || (instr_q == WRITE_ANY_OPCODE
                    && (addr_q == STATUS_ONE_NV_ADDR || addr_q == STATUS_ONE_V_ADDR
                        || addr_q == CONFIG_ONE_NV_ADDR || addr_q == CONFIG_ONE_V_ADDR));
    ignored_d = csRise && wrLock && cmdHit;
    hold_d    = hold_q;
    holdCnt_d = holdCnt_q;
    if (csRise && sentS) begin
      hold_d    = 1'b1;
      holdCnt_d = CS_CNT_W'(CS_CYCLES - 1);
    end else if (hold_q) begin
      if (holdCnt_q == '0 || !csS) begin
        hold_d = 1'b0;
      end else begin
        holdCnt_d = holdCnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csPrev_q  <= 1'b1;
      ignored_q <= 1'b0;
      hold_q    <= 1'b0;
      holdCnt_q <= '0;
    end else begin
      csPrev_q  <= csPrev_d;
      ignored_q <= ignored_d;
      hold_q    <= hold_d;
      holdCnt_q <= holdCnt_d;
    end
  end

  // hardware reset detection and power state
  logic                rstCond, rpDone_q, rpDone_d, hwReset_q, hwReset_d;
  logic                standby_q, standby_d, active_q, active_d;
  logic [RP_CNT_W-1:0] rpCnt_q, rpCnt_d;

  always_comb begin
    // only a deselected line three counts, so quad data never resets
    rstCond   = configTwoVolatile[RST_EN_BIT] && csS && !line3S;
    rpCnt_d   = rstCond ? rpCnt_q : '0;
    rpDone_d  = rstCond ? rpDone_q : 1'b0;
    hwReset_d = 1'b0;
    if (rstCond && !rpDone_q) begin
      if (rpCnt_q == RP_CNT_W'(RP_CYCLES - 1)) begin
        hwReset_d = 1'b1;
        rpDone_d  = 1'b1;
      end else begin
        rpCnt_d = rpCnt_q + 1'b1;
      end
    end
    standby_d = csS && !statusOneVolatile[WIP_BIT];
    active_d  = !csS;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rpCnt_q   <= '0;
      rpDone_q  <= 1'b0;
      hwReset_q <= 1'b0;
      standby_q <= 1'b0;
      active_q  <= 1'b0;
    end else begin
      rpCnt_q   <= rpCnt_d;
      rpDone_q  <= rpDone_d;
      hwReset_q <= hwReset_d;
      standby_q <= standby_d;
      active_q  <= active_d;
    end
  end

  assign line3HoldOe     = hold_q;
  assign rxValid         = rxValid_q;
  assign rxWord          = rxWord_q;
  assign txReady         = txReady_q;
  assign regWriteIgnored = ignored_q;
  assign hwReset         = hwReset_q;
  assign standbyPower    = standby_q;
  assign activePower     = active_q;

endmodule : sfp_pin_interface

`default_nettype wire

// File: sim/sfp_pin_interface_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sfp_pin_interface_sva (
  // system
  input wire logic                mclk,
  input wire logic                rst_n,
  // pins
  input wire logic                csN,
  input wire logic [3:0]          lineIn,
  input wire logic [3:0]          lineOe,
  input wire logic                line3HoldOe,
  // settings
  input wire logic [7:0]          statusOneVolatile,
  input wire logic [7:0]          statusOneNonvolatile,
  input wire logic [7:0]          configOneVolatile,
  input wire logic [7:0]          configTwoVolatile,
  input wire logic                fourLineCommandMode,
  input wire sfp_pkg::sfp_width_t laneWidth,
  // events and handshakes
  input wire logic                rxValid,
  input wire logic                txValid,
  input wire logic                txReady,
  input wire logic                regWriteIgnored,
  input wire logic                hwReset,
  input wire logic                standbyPower,
  input wire logic                activePower
);
  import sfp_pkg::*;
  logic [4:0] csHi_q, csHi_d, csLo_q, csLo_d, wipLo_q, wipLo_d, l3Lo_q, l3Lo_d, hold_q, hold_d;
  // saturating run-length counters
  function automatic logic [4:0] bump(input logic [4:0] v);
    return (v == 5'h1F) ? v : v + 5'h01;
  endfunction : bump
  always_comb begin
    csHi_d  = csN ? bump(csHi_q) : 5'h00;
    csLo_d  = csN ? 5'h00 : bump(csLo_q);
    wipLo_d = statusOneVolatile[WIP_BIT] ? 5'h00 : bump(wipLo_q);
    l3Lo_d  = (csN && !lineIn[3]) ? bump(l3Lo_q) : 5'h00;
    hold_d  = line3HoldOe ? bump(hold_q) : 5'h00;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {csHi_q, csLo_q, wipLo_q, l3Lo_q, hold_q} <= '0;
    end else begin
      {csHi_q, csLo_q, wipLo_q, l3Lo_q, hold_q} <= {csHi_d, csLo_d, wipLo_d, l3Lo_d, hold_d};
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_quiet8;
    !hwReset [*8];
  endsequence
  sequence s_busy8;
    statusOneVolatile[WIP_BIT] [*8];
  endsequence
  AST_OE_DESEL: assert property (csN |-> lineOe == 4'h0)
    else $error("line enabled while deselected");
  AST_X1_LANE: assert property (lineOe != 4'h0 && laneWidth == SFP_X1 && !fourLineCommandMode
    |-> lineOe == 4'h2)
    else $error("single-bit output not on line one");
  AST_QUAD_LANES: assert property (lineOe[3:2] != 2'b00 |-> configOneVolatile[QUAD_BIT])
    else $error("line two or three driven outside quad");
  AST_ACTIVE: assert property (csLo_q >= 5'h08 |-> activePower && !standbyPower)
    else $error("not active while selected");
  AST_STANDBY: assert property (csHi_q >= 5'h08 && wipLo_q >= 5'h08
    |-> standbyPower && !activePower)
    else $error("not in standby while idle");
  AST_WIP_BUSY: assert property (s_busy8 |-> !standbyPower)
    else $error("standby during running operation");
  AST_HWRST_COND: assert property (hwReset
    |-> configTwoVolatile[RST_EN_BIT] && l3Lo_q >= RP_CYCLES)
    else $error("reset without full pulse");
  AST_HWRST_ONCE: assert property (hwReset |=> s_quiet8)
    else $error("reset reported twice");
  AST_RX_PULSE: assert property (rxValid |=> !rxValid)
    else $error("receive strobe longer than one cycle");
  AST_TX_TAKE: assert property (txValid && txReady |=> !txReady)
    else $error("send ready stays high after take");
  AST_IGN_COND: assert property (regWriteIgnored |-> (!configOneVolatile[QUAD_BIT]
    && statusOneNonvolatile[SWD_BIT] && csHi_q inside {[5'h02:5'h0C]}) ##1 !regWriteIgnored)
    else $error("dropped write flagged wrongly");
  AST_HOLD_LEN: assert property (line3HoldOe |-> csN && hold_q < CS_CYCLES)
    else $error("line three hold outside deselect time");
endmodule : sfp_pin_interface_sva
`default_nettype wire

// File: sim/sfp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfp_host_model (
  // link
  output logic            sck,
  output logic            csN,
  // data lines
  output logic [3:0]      drv,
  output logic [3:0]      drvOe,
  input  wire logic [3:0] pin
);
  logic wpQ = 1'b1;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    drv = 4'h0;
    drvOe = 4'h0;
  end
  // settings cross on link edges, so pulse while deselected
  task automatic idle();
    repeat (4) begin
      #7 sck = 1'b1;
      #8 sck = 1'b0;
    end
  endtask : idle
  task automatic start(input logic wp);
    wpQ = wp;
    #3 csN = 1'b0;
  endtask : start
  task automatic xfer(input logic [7:0] tx, input int w, input bit rd, output logic [7:0] rx);
    int k;
    for (int g = 8 / w - 1; g >= 0; g--) begin
      drvOe = (rd && w == 4) ? 4'h0 : (rd ? 4'hC : (4'hC | 4'((1 << w) - 1)));
      drv = {1'b1, wpQ, 2'b00};
      for (k = 0; k < w; k++) if (!rd) drv[k] = tx[g * w + k];
      #7 sck = 1'b1;
      for (k = 0; k < w; k++) rx[g * w + k] = (w == 1) ? pin[1] : pin[k];
      #8 sck = 1'b0;
    end
    #60;
  endtask : xfer
  task automatic stop(input bit hold3);
    drv = 4'h8;
    drvOe = hold3 ? 4'h8 : 4'h0;
    #5 csN = 1'b1;
    #20 drvOe = 4'h0;
  endtask : stop
  task automatic pulse3(input int ns);
    drv = 4'h0;
    drvOe = 4'h8;
    #(ns) drv = 4'h8;
    #20 drvOe = 4'h0;
  endtask : pulse3
endmodule : sfp_host_model
`default_nettype wire

// File: sim/tb_sfp_pin_interface.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sfp_pin_interface;
  import sfp_pkg::*;
  logic         mclk = 1'b0, rst_n = 1'b0, sck, csN, line3HoldOe, rxValid, txReady;
  logic         regWriteIgnored, hwReset, standbyPower, activePower;
  logic         fourLineCommandMode = 1'b0, ddrMode = 1'b0, txValid = 1'b0;
  logic [3:0]   drv, drvOe, lineIn, lineOut, lineOe;
  logic [7:0]   statusOneVolatile = 8'h00, statusOneNonvolatile = 8'h80, txData = 8'h00;
  logic [7:0]   configOneVolatile = 8'h00, configTwoVolatile = 8'h00, rd0, rd1;
  sfp_width_t   laneWidth = SFP_X1;
  sfp_rx_word_t rxWord;
  sfp_rx_word_t rxQ[$];
  int           errors = 0, compares = 0, rstCnt = 0, ignCnt = 0;
  always #5 mclk = ~mclk;
  sfp_pin_interface i_dut (.*);
  sfp_host_model i_host (.sck(sck), .csN(csN), .drv(drv), .drvOe(drvOe), .pin(lineIn));
  // released lines 0/1 toggle, lines 2/3 pulled up
  always_comb begin
    for (int i = 0; i < 4; i++) lineIn[i] = lineOe[i] ? lineOut[i] : drvOe[i] ? drv[i] : (i > 1) | mclk;
    if (line3HoldOe) lineIn[3] = 1'b1;
  end
  always @(posedge mclk) begin
    if (rxValid) rxQ.push_back(rxWord);
    if (hwReset) rstCnt++;
    if (regWriteIgnored) ignCnt++;
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic setup(input sfp_width_t w, input logic fl, input logic qe);
    @(posedge mclk);
    laneWidth <= w;
    fourLineCommandMode <= fl;
    configOneVolatile <= {6'h00, qe, 1'b0};
    i_host.idle();
  endtask : setup
  task automatic scnPower();
    @(posedge mclk);
    statusOneVolatile <= 8'h02;
    repeat (12) @(posedge mclk);
    check("standbyBusy", standbyPower, 1'b0);
    statusOneVolatile <= 8'h00;
    repeat (12) @(posedge mclk);
    check("standbyIdle", {standbyPower, activePower}, 2'b10);
  endtask : scnPower
  task automatic scnRx();
    sfp_width_t wt[4] = '{SFP_X1, SFP_X2, SFP_X4, SFP_X4};
    logic [8:0] ex[3] = '{9'h1C5, 9'h096, 9'h03C};
    for (int i = 0; i < 4; i++) begin
      setup(wt[i], i == 3, i > 1);
      rxQ.delete();
      i_host.start(1'b1);
      i_host.xfer(8'hC5, i == 3 ? 4 : 1, 1'b0, rd0);
      i_host.xfer(8'h96, 1 << int'(wt[i]), 1'b0, rd0);
      i_host.xfer(8'h3C, 1 << int'(wt[i]), 1'b0, rd0);
      i_host.stop(1'b1);
      repeat (10) @(posedge mclk);
      check("rxCount", 9'(rxQ.size()), 9'h003);
      for (int j = 0; j < 3; j++) check("rxWord", rxQ[j], ex[j]);
    end
  endtask : scnRx
  task automatic scnRead();
    for (int i = 0; i < 2; i++) begin
      setup(i ? SFP_X4 : SFP_X1, 1'b0, i[0]);
      for (int n = 0; n < 20 && !txReady; n++) @(posedge mclk);
      @(posedge mclk);
      txValid <= 1'b1;
      txData <= 8'hA5;
      @(posedge mclk);
      txValid <= 1'b0;
      i_host.start(1'b1);
      i_host.xfer(8'h0B, 1, 1'b0, rd0);
      check("active", activePower, 1'b1);
      // output turns on only at a byte boundary after the instruction
      i_host.xfer(8'h00, i ? 4 : 1, 1'b0, rd0);
      i_host.xfer(8'h00, i ? 4 : 1, 1'b1, rd0);
      i_host.xfer(8'h00, i ? 4 : 1, 1'b1, rd1);
      check("read0", rd0, 9'h0A5);
      check("read1", rd1, 9'(IDLE_TX_BYTE));
      i_host.stop(1'b0);
      for (int n = 0; n < 8 && !line3HoldOe; n++) @(posedge mclk);
      check("hold3", line3HoldOe, 1'b1);
      check("oeIdle", lineOe, 4'h0);
    end
  endtask : scnRead
  task automatic scnWp();
    logic [7:0] op[5] = '{8'hA1, 8'hA1, 8'hA1, 8'hA2, 8'hA2};
    logic [7:0] ad[5] = '{8'h40, 8'h40, 8'h40, 8'h02, 8'h10};
    logic [4:0] wp = 5'b00010, qe = 5'b00100, ex = 5'b01001;
    int c;
    for (int i = 0; i < 5; i++) begin
      setup(SFP_X1, 1'b0, qe[i]);
      c = ignCnt;
      i_host.start(wp[i]);
      i_host.xfer(op[i], 1, 1'b0, rd0);
      i_host.xfer(8'h00, 1, 1'b0, rd0);
      i_host.xfer(8'h00, 1, 1'b0, rd0);
      i_host.xfer(ad[i], 1, 1'b0, rd0);
      i_host.stop(1'b1);
      repeat (15) @(posedge mclk);
      check("ignored", 9'(ignCnt - c), 9'(ex[i]));
    end
  endtask : scnWp
  task automatic scnReset();
    int ns[3] = '{300, 150, 300};
    int c;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      configTwoVolatile <= {2'b00, i < 2, 5'h00};
      repeat (4) @(posedge mclk);
      c = rstCnt;
      i_host.pulse3(ns[i]);
      repeat (10) @(posedge mclk);
      check("hwReset", 9'(rstCnt - c), 9'(i == 0));
    end
  endtask : scnReset
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    scnPower();
    scnRx();
    scnRead();
    scnWp();
    scnReset();
    summarize();
  end
  initial begin
    #300000;
    errors++;
    summarize();
  end
endmodule : tb_sfp_pin_interface
bind sfp_pin_interface sfp_pin_interface_sva i_sva (.*);
`default_nettype wire
